// ==== link_map.svh ====
// Register offsets, mode register addresses and timing counts of the link
`ifndef LINK_MAP_SVH
`define LINK_MAP_SVH

// ==========================================================
// Controller register offsets
`define REG_CTRL 3'h0
`define REG_STATUS 3'h1
`define REG_MRR_ADDR 3'h2
`define REG_MRW_ADDR 3'h3
`define REG_MRW_DATA 3'h4
`define REG_MRR_DATA 3'h5
`define REG_REF_LO 3'h6
`define REG_REF_HI 3'h7

// Control bits
`define CTRL_SR_ENTER 0
`define CTRL_SR_EXIT 1
`define CTRL_MRR 2
`define CTRL_MRW 3
`define CTRL_AUTO_REF 4

// Status bits
`define STAT_IN_SR 0
`define STAT_BUSY 1
`define STAT_MRR_DONE 2
`define STAT_NEED_REF 3

// ==========================================================
// Mode register addresses
`define MODE_TEMPERATURE 8'h04
`define MODE_BANK_MASK 8'h10
`define MODE_SEGMENT_MASK 8'h11
`define MODE_CAL_A 8'h20
`define MODE_CAL_B 8'h28

// Reset values
`define BANK_MASK_RESET 8'h00
`define SEGMENT_MASK_RESET 8'h00

// ==========================================================
// Timing
`define CLK_PERIOD_PS 5000
`define CK_HALF_CLKS 4
`define CK_PERIOD_PS (2 * `CK_HALF_CLKS * `CLK_PERIOD_PS)
`define REFRESH_WINDOW_MS 32
`define REFRESH_MIN_COUNT 8192
`define REFRESH_WINDOW_CK \
	((64'd1000000000 * `REFRESH_WINDOW_MS) / `CK_PERIOD_PS)
`define AVG_REFRESH_CK ((64'd1000000000 * `REFRESH_WINDOW_MS) / \
	(`REFRESH_MIN_COUNT * `CK_PERIOD_PS))
`define ALL_BANK_REFRESH_NS 130
`define ALL_BANK_REFRESH_CK \
	((`ALL_BANK_REFRESH_NS * 1000 + `CK_PERIOD_PS - 1) / `CK_PERIOD_PS)
`define BURST_GAP_CK \
	((4 * `ALL_BANK_REFRESH_NS * 1000 + `CK_PERIOD_PS - 1) / `CK_PERIOD_PS)
`define MIN_SR_RESIDENCY_NS 15
`define MIN_SR_RESIDENCY_CK \
	((`MIN_SR_RESIDENCY_NS * 1000 + `CK_PERIOD_PS - 1) / `CK_PERIOD_PS)
`define SR_INTERNAL_CLKS (`MIN_SR_RESIDENCY_NS * 1000 / `CLK_PERIOD_PS)
`define SR_EXIT_NS 140
`define SR_EXIT_CK ((`SR_EXIT_NS * 1000 + `CK_PERIOD_PS - 1) / `CK_PERIOD_PS)
`define STABLE_CLOCK_CK 2
`define MRR_PERIOD_CK 2
`define MRW_PERIOD_CK 5
`define READ_LATENCY 3
`define WRITE_LATENCY 1
`define STROBE_DELAY_MAX_PS 5500
`define MRR_TO_MRW_CK (`READ_LATENCY + \
	(`STROBE_DELAY_MAX_PS + `CK_PERIOD_PS - 1) / `CK_PERIOD_PS + 4 / 2 + 1)
`define MRR_TO_WRITE_CK (`MRR_TO_MRW_CK - `WRITE_LATENCY)

`endif

// ==== link_pkg.sv ====
// State types of the controller and the memory device
package link_pkg;

	typedef enum logic [2:0] {
		CTRL_IDLE, CTRL_MRR, CTRL_SR, CTRL_SR_CLK, CTRL_XSR
	} ctrl_state_type;

	typedef enum logic {MEM_IDLE, MEM_SR} mem_state_type;

	typedef struct packed {
		ctrl_state_type st;
		logic [1:0] div;
		logic ck;
		logic cke;
		logic cs_b;
		logic [9:0] ca_r;
		logic [9:0] ca_f;
		logic [7:0] wait_cnt;
		logic [7:0] ref_timer;
		logic [3:0] ref_gap;
		logic ref_pending;
		logic need_ref;
		logic auto_ref;
		logic req_sr;
		logic req_exit;
		logic req_mrr;
		logic req_mrw;
		logic [19:0] win_cnt;
		logic [13:0] win_refs;
		logic [13:0] last_refs;
		logic [7:0] mrr_addr;
		logic [7:0] mrw_addr;
		logic [7:0] mrw_data;
		logic [7:0] mrr_data;
		logic mrr_done;
		logic [9:0] dq_s1;
		logic [9:0] dq_s2;
		logic oe_d;
		logic oe_dd;
		logic [7:0] rdata;
	} ctrl_reg_type;

	typedef struct packed {
		mem_state_type st;
		logic ck_s1;
		logic ck_s2;
		logic ck_d;
		logic cke_s1;
		logic cke_s2;
		logic cs_s1;
		logic cs_s2;
		logic [9:0] car_s1;
		logic [9:0] car_s2;
		logic [9:0] caf_s1;
		logic [9:0] caf_s2;
		logic [7:0] bank_mask;
		logic [7:0] seg_mask;
		logic [7:0] mr_addr;
		logic [7:0] sr_timer;
		logic [3:0] lat;
		logic [1:0] beat;
		logic [7:0] dq;
		logic dq_oe;
		logic dqs;
		logic in_sr;
		logic [15:0] int_refs;
		logic [63:0] regions;
	} mem_reg_type;

endpackage : link_pkg

// ==== link_if.sv ====
// Command, clock and read data wires between controller and memory
`timescale 1ns/1ps

interface link_if;
	logic ck;
	logic cke;
	logic cs_b;
	logic [9:0] ca_r;
	logic [9:0] ca_f;
	logic [7:0] dq;
	logic dq_oe;
	logic dqs;

	modport controller (
		output ck,
		output cke,
		output cs_b,
		output ca_r,
		output ca_f,
		input dq,
		input dq_oe,
		input dqs
	);

	modport memory (
		input ck,
		input cke,
		input cs_b,
		input ca_r,
		input ca_f,
		output dq,
		output dq_oe,
		output dqs
	);
endinterface : link_if

// ==== mem_device.sv ====
// Memory device end: self refresh, array masking and mode register reads
`timescale 1ns/1ps
`include "link_map.svh"

module mem_device (
	input wire logic clk,
	input wire logic rst_b,
	link_if.memory link,
	input wire logic [7:0] temp_status,
	output logic self_refresh,
	output logic [15:0] internal_refresh_count,
	output logic [63:0] refreshed_regions,
	output logic [7:0] bank_mask,
	output logic [7:0] segment_mask
);

	link_pkg::mem_reg_type r;
	link_pkg::mem_reg_type n;

	// ==========================================================
	// Helpers

	// One bit per bank and segment: set where both are unmasked
	function automatic logic [63:0] region_map(input logic [7:0] bm,
		input logic [7:0] sm);
		logic [63:0] m;
		m = 64'h0;
		for (int b = 0; b < 8; b++) begin
			for (int s = 0; s < 8; s++) begin
				m[b * 8 + s] = ~bm[b] & ~sm[s];
			end
		end
		return m;
	endfunction : region_map

	function automatic logic [7:0] beat_data(input logic [7:0] a,
		input logic [1:0] bt, input logic [7:0] t);
		logic [7:0] d;
		d = 8'h00;
		if (a == `MODE_CAL_A) begin
			d = {8{~bt[0]}};
		end else if (a == `MODE_CAL_B) begin
			d = {8{bt[1]}};
		end else if (a == `MODE_TEMPERATURE && bt == 2'h0) begin
			d = t;
		end
		return d;
	endfunction : beat_data

	// ==========================================================
	// Next state
	always_comb begin
		logic rise;
		logic fall;
		logic [3:0] cmd;
		logic [7:0] ma;
		rise = r.ck_s2 & ~r.ck_d;
		fall = ~r.ck_s2 & r.ck_d;
		cmd = r.car_s2[3:0];
		ma = {r.car_s2[9:4], r.caf_s2[1:0]};
		n = r;
		n.ck_s1 = link.ck;
		n.ck_s2 = r.ck_s1;
		n.ck_d = r.ck_s2;
		n.cke_s1 = link.cke;
		n.cke_s2 = r.cke_s1;
		n.cs_s1 = link.cs_b;
		n.cs_s2 = r.cs_s1;
		n.car_s1 = link.ca_r;
		n.car_s2 = r.car_s1;
		n.caf_s1 = link.ca_f;
		n.caf_s2 = r.caf_s1;
		case (r.st)
			link_pkg::MEM_IDLE: begin
				if (rise && !r.cke_s2 && !r.cs_s2 && cmd[2:0] == 3'b100) begin
					n.st = link_pkg::MEM_SR;
					n.in_sr = 1'b1;
					n.sr_timer = 8'h00;
				end else if (rise && r.cke_s2 && !r.cs_s2) begin
					if (cmd == 4'b1000 && r.lat == 4'h0 && !r.dq_oe) begin
						n.mr_addr = ma;
						n.lat = 4'(`READ_LATENCY);
					end else if (cmd == 4'b0000) begin
						if (ma == `MODE_BANK_MASK) begin
							n.bank_mask = r.caf_s2[9:2];
						end
						if (ma == `MODE_SEGMENT_MASK) begin
							n.seg_mask = r.caf_s2[9:2];
						end
					end
				end
			end
			link_pkg::MEM_SR: begin
				// Internal timer keeps refreshing without the link clock
				if (r.sr_timer == 8'(`SR_INTERNAL_CLKS - 1)) begin
					n.sr_timer = 8'h00;
					n.int_refs = r.int_refs + 16'h0001;
					n.regions = region_map(r.bank_mask, r.seg_mask);
				end else begin
					n.sr_timer = r.sr_timer + 8'h01;
				end
				if (rise && r.cke_s2) begin
					n.st = link_pkg::MEM_IDLE;
					n.in_sr = 1'b0;
				end
			end
			default: begin
				n.st = link_pkg::MEM_IDLE;
			end
		endcase
		// Read burst of four beats, one per link clock edge
		if (rise && r.lat != 4'h0) begin
			n.lat = r.lat - 4'h1;
			if (r.lat == 4'h1) begin
				n.beat = 2'h0;
				n.dq = beat_data(r.mr_addr, 2'h0, temp_status);
				n.dq_oe = 1'b1;
				n.dqs = 1'b1;
			end
		end else if ((rise || fall) && r.dq_oe) begin
			if (r.beat == 2'h3) begin
				n.dq_oe = 1'b0;
				n.dqs = 1'b0;
				n.dq = 8'h00;
			end else begin
				n.beat = r.beat + 2'h1;
				n.dq = beat_data(r.mr_addr, r.beat + 2'h1, temp_status);
				n.dqs = ~r.dqs;
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
			r.bank_mask <= `BANK_MASK_RESET;
			r.seg_mask <= `SEGMENT_MASK_RESET;
		end else begin
			r <= n;
		end
	end

	assign link.dq = r.dq;
	assign link.dq_oe = r.dq_oe;
	assign link.dqs = r.dqs;
	assign self_refresh = r.in_sr;
	assign internal_refresh_count = r.int_refs;
	assign refreshed_regions = r.regions;
	assign bank_mask = r.bank_mask;
	assign segment_mask = r.seg_mask;

endmodule : mem_device

// ==== mem_controller.sv ====
// Memory controller end: refresh scheduling, self refresh, mode reg access
// Contract
// - Enough all-bank refreshes in every refresh window
// - Eight per-bank refreshes may replace one
// - At most eight all-bank refreshes per burst window
// - Self refresh time reduces the required count
// - Self refresh entry: CKE, CS, CA0, CA1 low, CA2 high
// - CKE high before entry, NOP after it
// - CKE low keeps self refresh, rest ignored
// - Device refreshes internally within minimum residency
// - Stay in self refresh for minimum residency
// - Clock may stop after entry, restart before exit
// - Two stable clocks before CKE rises
// - Only NOPs with CKE high during exit interval
// - One refresh between exit and next entry
// - All banks idle before self refresh entry
// - Bank mask blocks refresh of masked banks
// - Segment mask blocks refresh of masked segments
// - Mode read decode: CS, CA0-2 low, CA3 high
// - Register data on first beat, low byte
// - Mode read burst of four, NOPs for period
// - Mode read to mode write spacing kept
// - No mode read within half burst after read
// - Write to mode read spacing kept
// - First calibration register returns one zero one zero
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "link_map.svh"

module mem_controller #(
	parameter int unsigned REFRESH_WINDOW_CK = 32'(`REFRESH_WINDOW_CK)
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	link_if.controller link
);

	link_pkg::ctrl_reg_type r;
	link_pkg::ctrl_reg_type n;

	// ==========================================================
	// Next state
	always_comb begin
		logic last;
		logic fall;
		logic due;
		last = r.div == 2'(`CK_HALF_CLKS - 1);
		fall = last & r.ck;
		due = 1'b0;
		n = r;

		// Link clock divider, runs free in every state
		n.div = last ? 2'h0 : r.div + 2'h1;
		if (last) begin
			n.ck = ~r.ck;
		end

		// Read data capture through a two-stage synchroniser
		n.dq_s1 = {link.dqs, link.dq_oe, link.dq};
		n.dq_s2 = r.dq_s1;
		n.oe_d = r.dq_s2[8];
		n.oe_dd = r.oe_d;

		// ======================================================
		// Register port
		n.rdata = 8'h00;
		if (rd) begin
			case (addr)
				`REG_CTRL: n.rdata = {3'h0, r.auto_ref, r.req_mrw, r.req_mrr,
					r.req_exit, r.req_sr};
				`REG_STATUS: begin
					n.rdata = {4'h0, r.need_ref, r.mrr_done,
						r.st != link_pkg::CTRL_IDLE, r.st == link_pkg::CTRL_SR};
					n.mrr_done = 1'b0;
				end
				`REG_MRR_ADDR: n.rdata = r.mrr_addr;
				`REG_MRW_ADDR: n.rdata = r.mrw_addr;
				`REG_MRW_DATA: n.rdata = r.mrw_data;
				`REG_MRR_DATA: n.rdata = r.mrr_data;
				`REG_REF_LO: n.rdata = r.last_refs[7:0];
				`REG_REF_HI: n.rdata = {2'h0, r.last_refs[13:8]};
				default: n.rdata = 8'h00;
			endcase
		end
		if (wr) begin
			case (addr)
				`REG_CTRL: begin
					n.auto_ref = wdata[`CTRL_AUTO_REF];
				end
				`REG_MRR_ADDR: n.mrr_addr = wdata;
				`REG_MRW_ADDR: n.mrw_addr = wdata;
				`REG_MRW_DATA: n.mrw_data = wdata;
				default: begin
				end
			endcase
		end

		// First beat of a read burst; set wins over a status read
		if (r.oe_d && !r.oe_dd && r.st == link_pkg::CTRL_MRR) begin
			n.mrr_data = r.dq_s2[7:0];
			n.mrr_done = 1'b1;
		end

		// ======================================================
		// Command sequencer, one step per link clock cycle
		if (fall) begin
			n.cs_b = 1'b1;
			n.ca_r = 10'h000;
			n.ca_f = 10'h000;
			if (r.wait_cnt != 8'h00) begin
				n.wait_cnt = r.wait_cnt - 8'h01;
			end
			if (r.ref_gap != 4'h0) begin
				n.ref_gap = r.ref_gap - 4'h1;
			end

			// Refresh interval timer and fixed window count, cleared at each window end
			if (r.ref_timer == 8'(`AVG_REFRESH_CK - 1)) begin
				n.ref_timer = 8'h00;
				if (r.st == link_pkg::CTRL_SR) begin
					n.win_refs = r.win_refs + 14'h0001;
					n.ref_pending = 1'b0;
				end else if (r.auto_ref) begin
					n.ref_pending = 1'b1;
				end
			end else begin
				n.ref_timer = r.ref_timer + 8'h01;
			end
			if (r.win_cnt == 20'(REFRESH_WINDOW_CK - 1)) begin
				n.win_cnt = 20'h00000;
				n.last_refs = r.win_refs;
				n.win_refs = 14'h0000;
			end else begin
				n.win_cnt = r.win_cnt + 20'h00001;
			end

			due = r.ref_pending && r.ref_gap == 4'h0;
			case (r.st)
				link_pkg::CTRL_IDLE: begin
					n.req_exit = 1'b0;
					// No array reads or writes are issued, so no bank is
					// ever open and the read/write to mode read gaps hold
					if (r.wait_cnt != 8'h00) begin
						n.cs_b = 1'b1;
					end else if (due) begin
						// All-bank refresh only; per-bank refresh is unused
						n.cs_b = 1'b0;
						n.ca_r[2:0] = 3'b100;
						n.ref_pending = 1'b0;
						n.need_ref = 1'b0;
						n.ref_gap = 4'(`BURST_GAP_CK);
						n.wait_cnt = 8'(`ALL_BANK_REFRESH_CK);
						n.win_refs = r.win_refs + 14'h0001;
					end else if (r.req_mrw) begin
						n.cs_b = 1'b0;
						n.ca_r = {r.mrw_addr[7:2], 4'b0000};
						n.ca_f = {r.mrw_data, r.mrw_addr[1:0]};
						n.req_mrw = 1'b0;
						n.wait_cnt = 8'(`MRW_PERIOD_CK);
					end else if (r.req_mrr) begin
						n.cs_b = 1'b0;
						n.ca_r = {r.mrr_addr[7:2], 4'b1000};
						n.ca_f = {8'h00, r.mrr_addr[1:0]};
						n.req_mrr = 1'b0;
						n.st = link_pkg::CTRL_MRR;
						n.wait_cnt = 8'(`MRR_TO_MRW_CK);
					end else if (r.req_sr && !r.need_ref) begin
						// CKE was high in the cycle before this one
						n.cke = 1'b0;
						n.cs_b = 1'b0;
						n.ca_r[2:0] = 3'b100;
						n.req_sr = 1'b0;
						n.st = link_pkg::CTRL_SR;
						n.wait_cnt = 8'(`MIN_SR_RESIDENCY_CK);
					end
				end
				link_pkg::CTRL_MRR: begin
					// Only NOPs until burst and mode write gap are over
					if (r.wait_cnt == 8'h00) begin
						n.st = link_pkg::CTRL_IDLE;
					end
				end
				link_pkg::CTRL_SR: begin
					n.cke = 1'b0;
					if (r.req_exit && r.wait_cnt == 8'h00) begin
						n.req_exit = 1'b0;
						n.st = link_pkg::CTRL_SR_CLK;
						n.wait_cnt = 8'(`STABLE_CLOCK_CK);
					end
				end
				link_pkg::CTRL_SR_CLK: begin
					if (r.wait_cnt == 8'h00) begin
						n.cke = 1'b1;
						n.st = link_pkg::CTRL_XSR;
						n.need_ref = 1'b1;
						n.wait_cnt = 8'(`SR_EXIT_CK);
					end
				end
				link_pkg::CTRL_XSR: begin
					n.cke = 1'b1;
					if (r.wait_cnt == 8'h00) begin
						n.st = link_pkg::CTRL_IDLE;
					end
				end
				default: begin
					n.st = link_pkg::CTRL_IDLE;
				end
			endcase
		end

		// A request written as the sequencer takes the last one is kept
		if (wr && addr == `REG_CTRL) begin
			n.req_sr = n.req_sr | wdata[`CTRL_SR_ENTER];
			n.req_exit = n.req_exit | wdata[`CTRL_SR_EXIT];
			n.req_mrr = n.req_mrr | wdata[`CTRL_MRR];
			n.req_mrw = n.req_mrw | wdata[`CTRL_MRW];
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
			r.cke <= 1'b1;
			r.cs_b <= 1'b1;
			r.auto_ref <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign link.ck = r.ck;
	assign link.cke = r.cke;
	assign link.cs_b = r.cs_b;
	assign link.ca_r = r.ca_r;
	assign link.ca_f = r.ca_f;
	assign rdata = r.rdata;

endmodule : mem_controller

// ==== link_chk.sv ====
// Checker for the link between controller and memory device
`timescale 1ns/1ps

module link_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ck,
	input wire logic cke,
	input wire logic cs_b,
	input wire logic [9:0] ca_r,
	input wire logic [9:0] ca_f,
	input wire logic [7:0] dq,
	input wire logic dq_oe,
	input wire logic dqs
);
	int unsigned xsr_cnt;
	logic [7:0] gap;
	logic ref_on;

	assign ref_on = cke && !cs_b && ca_r[2:0] == 3'h4;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence sr_entry;
		$fell(cke) ##0 (!cs_b && ca_r[2:0] == 3'h4);
	endsequence

	sequence exit_start;
		$rose(cke);
	endsequence

	// ==========================================================
	// Exit window and refresh spacing counters
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xsr_cnt <= 0;
			gap <= 8'hff;
		end else begin
			if ($rose(cke))
				xsr_cnt <= 32;
			else if (xsr_cnt != 0)
				xsr_cnt <= xsr_cnt - 1;
			if (ref_on && !$past(ref_on))
				gap <= 8'h00;
			else if (gap != 8'hff)
				gap <= gap + 8'h01;
		end
	end

	// ==========================================================
	// Assertions
	a_sr_entry_code: assert property (
		$fell(cke) |-> !cs_b && ca_r[2:0] == 3'h4)
		else $error("self refresh entry with wrong code");
	a_cke_before_entry: assert property (
		$fell(cke) |-> $past(cke, 8))
		else $error("clock enable low before entry");
	a_nop_after_entry: assert property (
		sr_entry |-> ##[1:9] cs_b)
		else $error("no nop after self refresh entry");
	a_min_sr_residency: assert property (
		sr_entry |=> !cke [*7])
		else $error("self refresh left too early");
	a_clock_before_exit: assert property (
		exit_start |-> ck != $past(ck, 4))
		else $error("link clock not running at exit");
	a_nop_exit_window: assert property (
		xsr_cnt != 0 |-> cs_b && cke)
		else $error("command during exit interval");
	a_refresh_burst_gap: assert property (
		ref_on && !$past(ref_on) |-> gap >= 8'h67)
		else $error("refreshes too close together");
	a_burst_strobe_start: assert property (
		$rose(dq_oe) |-> dqs)
		else $error("mode read burst starts without strobe");
	a_strobe_toggles: assert property (
		dq_oe && $past(dq_oe, 4) |-> dqs != $past(dqs, 4))
		else $error("strobe stuck during mode read");
	a_quiet_mode_read: assert property (
		dq_oe |-> cs_b)
		else $error("command during mode read burst");
	a_sr_no_drive: assert property (
		!cke && !$past(cke, 4) |-> !dq_oe)
		else $error("device drives data in self refresh");
endmodule : link_chk

// ==== sdram_refresh_selfrefresh_mrr_tb.sv ====
// Bench joining controller and memory device across the link
`timescale 1ns/1ps
`include "link_map.svh"

module sdram_refresh_selfrefresh_mrr_tb;
	logic clk;
	logic rst_b;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic [7:0] temp_status;
	logic self_refresh;
	logic [15:0] irc;
	logic [63:0] regions;
	logic [7:0] bmask;
	logic [7:0] smask;
	logic [7:0] v;
	logic [63:0] exp_reg;
	logic [3:0] beats = 4'h0;
	logic last_dqs = 1'b0;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	int refs = 0;
	int r0;
	logic [7:0] ma [4] = '{8'h04, 8'h11, 8'h20, 8'h28};
	logic [7:0] md [4] = '{8'h03, 8'h00, 8'hff, 8'h00};
	logic [3:0] mb [4] = '{4'h0, 4'h0, 4'ha, 4'h3};
	localparam logic [7:0] BM = 8'h82;
	localparam logic [7:0] SM = 8'h84;

	link_if link ();
	mem_controller #(.REFRESH_WINDOW_CK(200)) u_mem_controller (.clk(clk),
		.rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .link(link));
	mem_device u_mem_device (.clk(clk), .rst_b(rst_b), .link(link),
		.temp_status(temp_status), .self_refresh(self_refresh),
		.internal_refresh_count(irc), .refreshed_regions(regions),
		.bank_mask(bmask), .segment_mask(smask));
	link_chk u_link_chk (.clk(clk), .rst_b(rst_b), .ck(link.ck),
		.cke(link.cke), .cs_b(link.cs_b), .ca_r(link.ca_r), .ca_f(link.ca_f),
		.dq(link.dq), .dq_oe(link.dq_oe), .dqs(link.dqs));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Monitors and timeout
	always @(posedge link.ck)
		if (link.cke && !link.cs_b && link.ca_r[2:0] == 3'h4)
			refs <= refs + 1;

	always @(posedge clk) begin
		last_dqs <= link.dqs;
		if (link.dq_oe && link.dqs !== last_dqs)
			beats <= {beats[2:0], link.dq[0]};
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	// ==========================================================
	// Tasks
	task automatic check(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_read

	task automatic poll(input int b, input logic val);
		logic [7:0] s;
		int n;
		s = ~{8{val}};
		for (n = 0; n < 600 && s[b] !== val; n++)
			reg_read(`REG_STATUS, s);
		check("status bit", val, s[b]);
	endtask : poll

	task automatic mode_write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] seen;
		int n;
		reg_write(`REG_MRW_ADDR, a);
		reg_write(`REG_MRW_DATA, d);
		reg_write(`REG_CTRL, 8'h18);
		seen = ~d;
		for (n = 0; n < 400 && seen !== d; n++) begin
			@(posedge clk);
			seen = a == `MODE_BANK_MASK ? bmask : smask;
		end
		check("mask", d, seen);
	endtask : mode_write

	task automatic mode_read(input logic [7:0] a, input logic [7:0] e);
		reg_write(`REG_MRR_ADDR, a);
		reg_write(`REG_CTRL, 8'h14);
		poll(`STAT_MRR_DONE, 1'b1);
		reg_read(`REG_MRR_DATA, v);
		check("mode read data", e, v);
	endtask : mode_read

	task complete_run;
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// ==========================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		temp_status = 8'h03;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check("bank mask reset", 8'h00, bmask);
		check("segment mask reset", 8'h00, smask);
		reg_read(`REG_CTRL, v);
		check("control", 8'h10, v);
		reg_write(`REG_CTRL, 8'h12);
		repeat (16) @(posedge clk);
		reg_read(`REG_CTRL, v);
		check("exit refused", 8'h10, v);
		reg_read(`REG_STATUS, v);
		check("idle exit", 1'b0, v[`STAT_IN_SR]);
		mode_write(`MODE_BANK_MASK, BM);
		mode_write(`MODE_SEGMENT_MASK, SM);
		for (int i = 0; i < 4; i++) begin
			mode_read(ma[i], md[i]);
			// Let the last beats of the burst pass
			repeat (16) @(posedge clk);
			if (i > 1)
				check("burst beats", mb[i], beats);
		end
		reg_write(`REG_CTRL, 8'h11);
		poll(`STAT_IN_SR, 1'b1);
		check("clock enable", 1'b0, link.cke);
		repeat (16) @(posedge clk);
		check("device entered", 1'b1, self_refresh);
		check("internal refresh", 1'b1, irc != 16'h0000);
		for (int b = 0; b < 8; b++)
			for (int s = 0; s < 8; s++)
				exp_reg[b * 8 + s] = !BM[b] && !SM[s];
		check("regions", exp_reg, regions);
		r0 = refs;
		reg_write(`REG_CTRL, 8'h12);
		poll(`STAT_IN_SR, 1'b0);
		poll(`STAT_BUSY, 1'b0);
		check("device left", 1'b0, self_refresh);
		reg_write(`REG_CTRL, 8'h11);
		poll(`STAT_IN_SR, 1'b1);
		check("refresh before entry", 1'b1, refs > r0);
		reg_write(`REG_CTRL, 8'h12);
		poll(`STAT_IN_SR, 1'b0);
		repeat (3400) @(posedge clk);
		reg_read(`REG_REF_LO, v);
		check("window refreshes", 1'b1, v >= 8'h02);
		reg_read(`REG_REF_HI, v);
		check("window count high", 8'h00, v);
		reg_write(`REG_CTRL, 8'h00);
		repeat (3400) @(posedge clk);
		reg_read(`REG_REF_LO, v);
		check("idle window", 8'h00, v);
		complete_run();
	end
endmodule : sdram_refresh_selfrefresh_mrr_tb
